// ===== include/irq_route_consts.svh
`ifndef IRQ_ROUTE_CONSTS_SVH
`define IRQ_ROUTE_CONSTS_SVH

// irq pin count and each line's slot
`define NUM_LINES       10
`define L3              0
`define L4              1
`define L5              2
`define L6              3
`define L7              4
`define L9              5
`define L10             6
`define L11             7
`define L12             8
`define L15             9

// source slots: none plus eight
`define NUM_SRC         9

// register byte addresses
`define ADDR_CTRL       8'h00
`define ADDR_ISTAT      8'h04
`define ADDR_IEN        8'h08
`define ADDR_ICLR       8'h0c
`define ADDR_PINS       8'h10
`define ADDR_ROUTE0     8'h40
`define ADDR_ROUTE_END  8'h64

// field widths and reset values
`define CTRL_W          13
`define ROUTE_W         5
`define CTRL_RST        13'h01c0
`define ROUTE_RST       5'h00
`define IEN_RST         10'h000
`define RDATA_ZERO      32'h0000_0000

`endif

// ===== include/irq_route_pkg.sv
`include "irq_route_consts.svh"
package irq_route_pkg;

    // source selection for a configurable line
    typedef enum logic [3:0] {
        SRC_NONE  = 4'h0,
        SRC_UART1 = 4'h1,
        SRC_UART2 = 4'h2,
        SRC_UARTS = 4'h3,
        SRC_LPT   = 4'h4,
        SRC_FDC   = 4'h5,
        SRC_EXT1  = 4'h6,
        SRC_EXT2  = 4'h7,
        SRC_EXT3  = 4'h8
    } src_t;

    // per-line routing register
    typedef struct packed {
        logic open_drain;   // 1: pull low while asserted, else float
        src_t sel;          // selected source
    } route_t;

    // global control register, msb first
    typedef struct packed {
        logic fdc_irq_en;   // 12
        logic ms_en2;       // 11 modem-status irq enable, channel 2
        logic ms_en1;       // 10
        logic alt_rate;     // 9  rate output level on line 5 pin
        logic l5_irq;       // 8  line 5 pin is an interrupt line
        logic l15_irq;      // 7  line 15 pin is an interrupt line
        logic l12_irq;      // 6  line 12 pin is an interrupt line
        logic ser2_low;     // 5  channel 2 on line 3
        logic ser1_low;     // 4  channel 1 on line 3
        logic lpt_on5;      // 3  legacy parallel irq on line 5, else 7
        logic lpt_en;       // 2  parallel interrupt enable
        logic ecp_en;       // 1  extended capabilities parallel mode
        logic cfg_mode;     // 0  configurable routing, else legacy
    } ctrl_t;

    // serial channel interrupt sources
    typedef struct packed {
        logic irq;          // channel interrupt request
        logic irq_en;       // channel interrupt enable
        logic dsr_chg;      // data_set_ready_change_flag
    } ser_src_t;

    // floppy controller interrupt sources
    typedef struct packed {
        logic exec_done;    // execution phase complete
        logic data_ready;   // byte ready for the host
        logic dma_mode;     // transfers run through dma
    } fdc_src_t;

    // whole block state
    typedef struct packed {
        ctrl_t                   ctrl;
        route_t [`NUM_LINES-1:0] route;
        logic [`NUM_LINES-1:0]   act;
        logic [`NUM_LINES-1:0]   istat;
        logic [`NUM_LINES-1:0]   ien;
        logic [`NUM_LINES-1:0]   pin_out;
        logic [`NUM_LINES-1:0]   pin_oe;
        logic                    dsr2_n;
        logic                    ir_rx2;
        logic                    lpt_pin_in;
        logic                    irq;
        logic [31:0]             rdata;
    } state_t;

endpackage

// ===== design/multi_io_interrupt_routing.sv
// Functional notes
// R1: each configurable line totem-pole or open-drain
// R2: lines 3,4,5,6,7,9,10,11,12,15 are assignable
// R3: each line driven from one selected source
// R4: lines 12, 15, 5 share pins
// R5: legacy serial irq on line 3 or 4
// R6: legacy serial line drops after host service
// R7: legacy line 5 follows acknowledge when enabled
// R8: legacy line 7 follows acknowledge when enabled
// R9: line 7 bidirectional only with ECP configured
// R10: line 5 bidirectional only with ECP configured
// R11: legacy line 6 on floppy execution complete
// R12: line 6 on non-DMA floppy data ready
// R13: data-set-ready change raises serial interrupt
// R14: unassigned or disabled line is tri-stated; legacy mode always drives lines 3, 4 and 6
// R15: routing mode set at reset, changed by software
//
// Added by the designer: the address-and-strobe port and the register addresses.

`timescale 1ns/100ps
`default_nettype none
`include "irq_route_consts.svh"

module multi_io_interrupt_routing (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic [7:0]              reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [31:0]                  reg_rdata,

    input  wire irq_route_pkg::ser_src_t ser1,
    input  wire irq_route_pkg::ser_src_t ser2,
    input  wire irq_route_pkg::fdc_src_t fdc,
    input  wire logic                    ack_n,
    input  wire logic                    external_irq_input_2,
    input  wire logic                    external_irq_input_3,

    input  wire logic [`NUM_LINES-1:0]   irq_pin_in,
    output logic [`NUM_LINES-1:0]        irq_pin_out,
    output logic [`NUM_LINES-1:0]        irq_pin_oe,

    output logic                         data_set_ready_2_n,
    output logic                         infrared_receive_2,
    output logic                         lpt_irq_pin_in,
    output logic                         irq
);
    import irq_route_pkg::*;

    logic [1:0]            rst_sync_q;  // reset release synchroniser
    logic                  rst_ok;      // synchronised reset, high = running

    state_t                st_q;        // registered state
    state_t                st_d;        // next state

    logic [`NUM_SRC-1:0]   src_act;     // request level per source slot
    logic [`NUM_SRC-1:0]   src_en;      // enable per source slot

    logic                  ser1_act;    // channel 1 request
    logic                  ser2_act;    // channel 2 request
    logic                  lpt_act;     // parallel request level
    logic                  fdc_act;     // floppy request level
    logic                  ext1;        // external input 1 from line 15 pin

    logic [`NUM_LINES-1:0] leg_act;     // legacy request per line
    logic [`NUM_LINES-1:0] leg_en;      // legacy drive enable per line
    logic [`NUM_LINES-1:0] line_act;    // logical request per line
    logic [`NUM_LINES-1:0] line_out;    // pin value before sharing
    logic [`NUM_LINES-1:0] line_oe;     // pin enable before sharing

    logic [3:0]            route_idx;   // routing index from address

    // async assert, two-flop release: no runt reset edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_ok = rst_sync_q[1];

    // source levels; a uart request stays until the host services it
    assign ser1_act = ser1.irq | (ser1.dsr_chg & st_q.ctrl.ms_en1); // R13 R6
    assign ser2_act = ser2.irq | (ser2.dsr_chg & st_q.ctrl.ms_en2); // R13 R6

    assign lpt_act  = ack_n;                                        // R7 R8
    assign fdc_act  = fdc.exec_done | (fdc.data_ready & ~fdc.dma_mode); // R11 R12
    // line 15 pin feeds external input 1 when not an irq line
    assign ext1     = ~st_q.ctrl.l15_irq & irq_pin_in[`L15];        // R4

    // source table indexed by the selection code
    always_comb begin
        src_act = '0;
        src_en  = '0;

        src_act[SRC_UART1] = ser1_act;
        src_en[SRC_UART1]  = ser1.irq_en;

        src_act[SRC_UART2] = ser2_act;
        src_en[SRC_UART2]  = ser2.irq_en;

        src_act[SRC_UARTS] = (ser1_act & ser1.irq_en) | (ser2_act & ser2.irq_en);
        src_en[SRC_UARTS]  = ser1.irq_en | ser2.irq_en;

        src_act[SRC_LPT]   = lpt_act;
        src_en[SRC_LPT]    = st_q.ctrl.lpt_en;

        src_act[SRC_FDC]   = fdc_act;
        src_en[SRC_FDC]    = st_q.ctrl.fdc_irq_en;

        src_act[SRC_EXT1]  = ext1;
        src_en[SRC_EXT1]   = ~st_q.ctrl.l15_irq;

        src_act[SRC_EXT2]  = external_irq_input_2;
        src_en[SRC_EXT2]   = 1'b1;

        src_act[SRC_EXT3]  = external_irq_input_3;
        src_en[SRC_EXT3]   = 1'b1;
    end

    // fixed legacy map; lines not listed float
    always_comb begin
        leg_act = '0;
        leg_en  = '0;

        leg_act[`L3] = (st_q.ctrl.ser1_low & ser1_act & ser1.irq_en)
                     | (st_q.ctrl.ser2_low & ser2_act & ser2.irq_en);      // R5
        leg_act[`L4] = (~st_q.ctrl.ser1_low & ser1_act & ser1.irq_en)
                     | (~st_q.ctrl.ser2_low & ser2_act & ser2.irq_en);     // R5

        leg_en[`L3]  = 1'b1;
        leg_en[`L4]  = 1'b1;

        leg_act[`L6] = fdc_act;                                            // R11 R12
        leg_en[`L6]  = 1'b1;

        leg_act[`L5] = lpt_act;                                            // R7
        leg_en[`L5]  = st_q.ctrl.lpt_en & st_q.ctrl.lpt_on5;               // R7

        leg_act[`L7] = lpt_act;                                            // R8
        leg_en[`L7]  = st_q.ctrl.lpt_en & ~st_q.ctrl.lpt_on5;              // R8
    end

    // per-line driver
    for (genvar i = 0; i < `NUM_LINES; i++) begin : g_line                 // R2
        logic cfg_ok;   // selection is a real, enabled source
        logic drv;      // line is driven by its source

        assign cfg_ok = (st_q.route[i].sel <= SRC_EXT3)
                      && src_en[st_q.route[i].sel];                        // R3 R14
        assign drv    = st_q.ctrl.cfg_mode ? cfg_ok : leg_en[i];           // R15
        assign line_act[i] = drv && (st_q.ctrl.cfg_mode ?
                             src_act[st_q.route[i].sel] : leg_act[i]);     // R3

        // open drain only ever pulls low
        always_comb begin
            if (st_q.ctrl.cfg_mode && st_q.route[i].open_drain) begin      // R1
                line_out[i] = 1'b0;
                line_oe[i]  = line_act[i];
            end else begin
                line_out[i] = line_act[i];
                line_oe[i]  = drv;                                         // R14
            end
        end
    end

    assign route_idx = 4'((reg_addr - `ADDR_ROUTE0) >> 2);

    // next state: registers, pin sharing, sticky status, read port
    always_comb begin
        st_d = st_q;
        // pin drivers before sharing overrides
        st_d.pin_out = line_out;
        st_d.pin_oe  = line_oe;

        // line 12 pin doubles as modem and infrared input
        if (!st_q.ctrl.l12_irq) begin                                      // R4
            st_d.pin_oe[`L12]  = 1'b0;
            st_d.pin_out[`L12] = 1'b0;
        end

        // line 15 pin doubles as external interrupt input 1
        if (!st_q.ctrl.l15_irq) begin                                      // R4
            st_d.pin_oe[`L15]  = 1'b0;
            st_d.pin_out[`L15] = 1'b0;
        end

        // line 5 pin doubles as alternate_rate_select_0 output
        if (!st_q.ctrl.l5_irq) begin                                       // R4
            st_d.pin_oe[`L5]  = 1'b1;
            st_d.pin_out[`L5] = st_q.ctrl.alt_rate;
        end

        // shared inputs idle high while the pin is an irq line
        st_d.dsr2_n = st_q.ctrl.l12_irq | irq_pin_in[`L12];                // R4
        st_d.ir_rx2 = st_q.ctrl.l12_irq | irq_pin_in[`L12];                // R4

        // parallel pin read back only as the ECP interrupt
        st_d.lpt_pin_in = 1'b0;
        if (st_q.ctrl.ecp_en) begin
            if (st_q.ctrl.cfg_mode ? (st_q.route[`L7].sel == SRC_LPT)
                                   : (st_q.ctrl.lpt_en & ~st_q.ctrl.lpt_on5)) begin
                st_d.lpt_pin_in = irq_pin_in[`L7];                         // R9
            end else if (st_q.ctrl.l5_irq && (st_q.ctrl.cfg_mode ?
                         (st_q.route[`L5].sel == SRC_LPT)
                         : (st_q.ctrl.lpt_en & st_q.ctrl.lpt_on5))) begin
                st_d.lpt_pin_in = irq_pin_in[`L5];                         // R10
            end
        end

        // rising request edge sets status; a set beats a same-cycle clear
        st_d.act   = line_act;
        st_d.istat = st_q.istat | (line_act & ~st_q.act);
        if (reg_wr && (reg_addr == `ADDR_ICLR)) begin
            st_d.istat = (st_q.istat & ~reg_wdata[`NUM_LINES-1:0])
                       | (line_act & ~st_q.act);
        end

        // software writes; routing changes only here
        if (reg_wr) begin
            if (reg_addr == `ADDR_CTRL) begin
                st_d.ctrl = ctrl_t'(reg_wdata[`CTRL_W-1:0]);               // R15
            end else if (reg_addr == `ADDR_IEN) begin
                st_d.ien = reg_wdata[`NUM_LINES-1:0];
            end else if ((reg_addr >= `ADDR_ROUTE0) && (reg_addr <= `ADDR_ROUTE_END)
                         && (reg_addr[1:0] == 2'h0)) begin
                st_d.route[route_idx] = route_t'(reg_wdata[`ROUTE_W-1:0]);  // R3
            end
        end

        // level interrupt from the next status, registered with it
        st_d.irq = |(st_d.istat & st_d.ien);

        // read data stand one cycle, zero otherwise and for holes
        st_d.rdata = `RDATA_ZERO;

        if (reg_rd) begin
            case (reg_addr)
                `ADDR_CTRL:  st_d.rdata = 32'(st_q.ctrl);
                `ADDR_ISTAT: st_d.rdata = 32'(st_q.istat);
                `ADDR_IEN:   st_d.rdata = 32'(st_q.ien);
                `ADDR_PINS:  st_d.rdata = {12'h000, 10'(st_q.act), 10'(irq_pin_in)};
                default: begin
                    if ((reg_addr >= `ADDR_ROUTE0) && (reg_addr <= `ADDR_ROUTE_END)
                        && (reg_addr[1:0] == 2'h0)) begin
                        st_d.rdata = 32'(st_q.route[route_idx]);
                    end
                end
            endcase
        end
    end

    // one register for the whole state; reset gives legacy routing
    always_ff @(posedge ref_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            st_q        <= '0;

            st_q.ctrl   <= ctrl_t'(`CTRL_RST);                             // R15
            st_q.ien    <= `IEN_RST;

            st_q.dsr2_n <= 1'b1;
            st_q.ir_rx2 <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata          = st_q.rdata;

    assign irq_pin_out        = st_q.pin_out;
    assign irq_pin_oe         = st_q.pin_oe;
    assign data_set_ready_2_n = st_q.dsr2_n;
    assign infrared_receive_2 = st_q.ir_rx2;
    assign lpt_irq_pin_in     = st_q.lpt_pin_in;
    assign irq                = st_q.irq;

    // checks, sampled on the running clock
    default clocking cb @(posedge ref_clk); endclocking

    default disable iff (!rst_ok);

    // no register write this cycle
    sequence s_quiet;
        !reg_wr;
    endsequence

    // legacy mode held steady
    sequence s_legacy;
        !st_q.ctrl.cfg_mode && !reg_wr;
    endsequence

    a_od_no_high: assert property (                                         // R1
        (st_q.ctrl.cfg_mode && st_q.route[`L3].open_drain && st_q.ctrl.l5_irq)
        and s_quiet
        |=> !irq_pin_out[`L3])
        else $error("open-drain line driven high");

    a_unassigned_float: assert property (                                   // R14
        (st_q.ctrl.cfg_mode && st_q.route[`L9].sel == SRC_NONE) and s_quiet
        |=> !irq_pin_oe[`L9])
        else $error("unassigned line not tri-stated");

    a_line5_rate: assert property (                                         // R4
        (!st_q.ctrl.l5_irq) and s_quiet
        |=> irq_pin_oe[`L5] && irq_pin_out[`L5] == $past(st_q.ctrl.alt_rate))
        else $error("line 5 pin not the rate output");

    a_line12_dsr: assert property (                                         // R4
        (!st_q.ctrl.l12_irq) and s_quiet
        |=> !irq_pin_oe[`L12] && data_set_ready_2_n == $past(irq_pin_in[`L12]))
        else $error("line 12 pin not passed to dsr input");

    a_legacy_fdc: assert property (                                         // R11
        s_legacy and fdc.exec_done
        |=> irq_pin_oe[`L6] && irq_pin_out[`L6])
        else $error("floppy completion not on line 6");

    a_legacy_com1: assert property (                                        // R5
        s_legacy and (ser1.irq && ser1.irq_en && !st_q.ctrl.ser1_low)
        |=> irq_pin_out[`L4] ##0 irq_pin_oe[`L4])
        else $error("channel 1 request not on line 4");

    a_lpt_tristate: assert property (                                       // R8
        s_legacy and !st_q.ctrl.lpt_en
        |=> !irq_pin_oe[`L7])
        else $error("disabled parallel line 7 driven");

    a_status_sets: assert property (
        $rose(line_act[`L3]) |=> st_q.istat[`L3] ##1 irq == st_q.ien[`L3] || !st_q.istat[`L3]
        || irq)
        else $error("line 3 edge did not set status");

    a_read_one_cycle: assert property (
        !reg_rd |=> reg_rdata == `RDATA_ZERO)
        else $error("read data outside the answer cycle");

    a_ecp_readback: assert property (                                       // R9
        !st_q.ctrl.ecp_en |=> !lpt_irq_pin_in)
        else $error("line read back without ECP mode");

endmodule
`default_nettype wire

// ===== verification/host_irq_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "irq_route_consts.svh"

// host interrupt controller side of the request pins
module host_irq_model (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic [`NUM_LINES-1:0] pin_out,  // device drive value
    input  wire logic [`NUM_LINES-1:0] pin_oe,   // device output enable
    input  wire logic [`NUM_LINES-1:0] ext_oe,   // other agent drives pin
    input  wire logic [`NUM_LINES-1:0] ext_val,  // other agent value
    input  wire logic [`NUM_LINES-1:0] eoi,      // service routine done
    output logic      [`NUM_LINES-1:0] wire_lvl, // resolved pin level
    output logic      [`NUM_LINES-1:0] pending   // latched requests
);
    logic [`NUM_LINES-1:0] lvl_q;  // level one edge ago, for edge detect

    // released pins float high; contention reads x
    always_comb begin
        for (int i = 0; i < `NUM_LINES; i++) begin
            if (pin_oe[i] && ext_oe[i]) begin
                wire_lvl[i] = 1'bx;
            end else if (pin_oe[i]) begin
                wire_lvl[i] = pin_out[i];
            end else if (ext_oe[i]) begin
                wire_lvl[i] = ext_val[i];
            end else begin
                wire_lvl[i] = 1'b1;
            end
        end
    end

    // rising edges stay pending until serviced
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_q   <= '1;  // pull-up level, so no false edge after reset
            pending <= '0;
        end else begin
            lvl_q   <= wire_lvl;
            pending <= (pending & ~eoi) | (wire_lvl & ~lvl_q & pin_oe);
        end
    end
endmodule
`default_nettype wire

// ===== verification/test_multi_io_interrupt_routing.sv
`timescale 1ns/100ps
`default_nettype none
`include "irq_route_consts.svh"

module test_multi_io_interrupt_routing;
    import irq_route_pkg::*;

    // table row: control, route, sources, pin result
    typedef struct packed {
        logic [12:0] ctrl;
        logic [4:0]  route;
        logic [11:0] src;   // {ser1, ser2, fdc, ack_n, ext2, ext3}
        logic [9:0]  oe;
        logic [9:0]  out;
        logic [9:0]  mask;  // lines looked at
    } row_t;

    logic                  ref_clk, rst_n, reg_wr, reg_rd, ack_n, ext2, ext3;
    logic [7:0]            reg_addr;
    logic [31:0]           reg_wdata, reg_rdata;
    ser_src_t              ser1, ser2;
    fdc_src_t              fdc;
    logic [`NUM_LINES-1:0] pin_in, pin_out, pin_oe, ext_oe, ext_val, eoi, pending;
    logic                  dsr2_n, ir_rx2, lpt_in, irq;
    int                    errors, checked;

    // legacy rows watch lines 3..7
    row_t rows [25] = '{
        '{13'h11c0, 5'h00, 12'hc00, 10'h00b, 10'h002, 10'h01f},
        '{13'h11e0, 5'h00, 12'h180, 10'h00b, 10'h001, 10'h01f},
        '{13'h11d0, 5'h00, 12'hc00, 10'h00b, 10'h001, 10'h01f},
        '{13'h15c0, 5'h00, 12'h600, 10'h00b, 10'h002, 10'h01f},
        '{13'h11c0, 5'h00, 12'h600, 10'h00b, 10'h000, 10'h01f},
        '{13'h11c0, 5'h00, 12'h020, 10'h00b, 10'h008, 10'h01f},
        '{13'h11c0, 5'h00, 12'h010, 10'h00b, 10'h008, 10'h01f},
        '{13'h11c0, 5'h00, 12'h018, 10'h00b, 10'h000, 10'h01f},
        '{13'h11cc, 5'h00, 12'h004, 10'h00f, 10'h004, 10'h01f},
        '{13'h11cc, 5'h00, 12'h000, 10'h00f, 10'h000, 10'h01f},
        '{13'h11c4, 5'h00, 12'h004, 10'h01b, 10'h010, 10'h01f},
        '{13'h11c0, 5'h00, 12'h004, 10'h00b, 10'h000, 10'h01f},
        '{13'h12c0, 5'h00, 12'h000, 10'h00f, 10'h004, 10'h01f},
        '{13'h11c5, 5'h01, 12'hc00, 10'h3ff, 10'h3ff, 10'h3ff},
        '{13'h11c5, 5'h02, 12'hc00, 10'h000, 10'h000, 10'h3ff},
        '{13'h11c5, 5'h03, 12'h180, 10'h3ff, 10'h3ff, 10'h3ff},
        '{13'h11c5, 5'h04, 12'h004, 10'h3ff, 10'h3ff, 10'h3ff},
        '{13'h11c5, 5'h05, 12'h020, 10'h3ff, 10'h3ff, 10'h3ff},
        '{13'h11c5, 5'h07, 12'h002, 10'h3ff, 10'h3ff, 10'h3ff},
        '{13'h11c5, 5'h08, 12'h001, 10'h3ff, 10'h3ff, 10'h3ff},
        '{13'h11c5, 5'h08, 12'h002, 10'h3ff, 10'h000, 10'h3ff},
        '{13'h11c5, 5'h11, 12'hc00, 10'h3ff, 10'h000, 10'h3ff},
        '{13'h11c5, 5'h11, 12'h000, 10'h000, 10'h000, 10'h3ff},
        '{13'h11c5, 5'h00, 12'hc00, 10'h000, 10'h000, 10'h3ff},
        '{13'h11c5, 5'h19, 12'hc00, 10'h000, 10'h000, 10'h3ff}
    };

    multi_io_interrupt_routing u_multi_io_interrupt_routing (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ser1(ser1),
        .ser2(ser2), .fdc(fdc), .ack_n(ack_n), .external_irq_input_2(ext2),
        .external_irq_input_3(ext3), .irq_pin_in(pin_in), .irq_pin_out(pin_out),
        .irq_pin_oe(pin_oe), .data_set_ready_2_n(dsr2_n),
        .infrared_receive_2(ir_rx2), .lpt_irq_pin_in(lpt_in), .irq(irq)
    );

    host_irq_model u_host_irq_model (
        .ref_clk(ref_clk), .rst_n(rst_n), .pin_out(pin_out), .pin_oe(pin_oe),
        .ext_oe(ext_oe), .ext_val(ext_val), .eoi(eoi), .wire_lvl(pin_in),
        .pending(pending)
    );

    // 25 MHz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        $display("[FAIL] run length expected finish seen timeout");
        results();
    end

    task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask

    // single-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // data stand only the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 chk_val(n, e, reg_rdata);
    endtask

    // pins trail sources by one edge; three for margin
    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic cfg(input logic [12:0] c, input logic [4:0] r);
        wr(`ADDR_CTRL, 32'(c));
        for (int i = 0; i < `NUM_LINES; i++) begin
            wr(`ADDR_ROUTE0 + 8'(4 * i), 32'(r));
        end
    endtask

    task automatic set_src(input logic [11:0] s);
        @(posedge ref_clk);
        {ser1, ser2, fdc, ack_n, ext2, ext3} <= s;
    endtask

    // parallel pin readback, extended mode only
    task automatic lpt_chk(input logic [12:0] c, input logic a, input logic e);
        wr(`ADDR_CTRL, 32'(c));
        @(posedge ref_clk);
        ack_n <= a;
        settle();
        chk_bit("lpt pin readback", e, lpt_in);
    endtask

    initial begin
        rst_n = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {ser1, ser2, fdc, ack_n, ext2, ext3} = 12'h004;
        {ext_oe, ext_val, eoi} = '0;
        errors = 0;
        checked = 0;
        repeat (8) @(posedge ref_clk);
        #1 chk_bit("dsr2 in reset", 1'b1, dsr2_n);
        chk_bit("ir rx2 in reset", 1'b1, ir_rx2);
        chk_val("oe in reset", 32'h0, 32'(pin_oe));
        @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(`ADDR_CTRL, 32'h1c0, "ctrl reset");
        rd(`ADDR_IEN, 32'h0, "ien reset");
        rd(`ADDR_ISTAT, 32'h0, "istat reset");
        rd(`ADDR_ROUTE0, 32'h0, "route reset");
        $display("reset test done");

        foreach (rows[k]) begin
            cfg(rows[k].ctrl, rows[k].route);
            set_src(rows[k].src);
            settle();
            chk_val("pin oe", 32'(rows[k].oe & rows[k].mask), 32'(pin_oe & rows[k].mask));
            chk_val("pin out", 32'(rows[k].out & rows[k].oe & rows[k].mask),
                    32'(pin_out & rows[k].oe & rows[k].mask));
        end
        $display("routing table done");

        // host latches the request, services it, it drops
        cfg(13'h11c0, 5'h00);
        set_src(12'h000);
        @(posedge ref_clk);
        eoi <= '1;
        @(posedge ref_clk);
        eoi <= '0;
        set_src(12'hc00);
        settle();
        chk_bit("host pending", 1'b1, pending[`L4]);
        @(posedge ref_clk);
        ser1.irq <= 1'b0;
        eoi      <= '1;
        @(posedge ref_clk);
        eoi      <= '0;
        settle();
        chk_bit("line 4 after service", 1'b0, pin_out[`L4]);
        chk_bit("pending after service", 1'b0, pending[`L4]);
        $display("service test done");

        // sticky status, enable mask, write-one clear
        wr(`ADDR_ICLR, 32'h3ff);
        wr(`ADDR_IEN, 32'h0);
        set_src(12'h020);
        settle();
        rd(`ADDR_ISTAT, 32'h008, "istat floppy");
        chk_bit("irq masked", 1'b0, irq);
        wr(`ADDR_IEN, 32'h008);
        settle();
        chk_bit("irq enabled", 1'b1, irq);
        wr(`ADDR_ICLR, 32'h008);
        settle();
        rd(`ADDR_ISTAT, 32'h0, "istat cleared");
        chk_bit("irq cleared", 1'b0, irq);
        rd(`ADDR_ICLR, 32'h0, "iclr reads zero");
        rd(`ADDR_IEN, 32'h008, "ien readback");
        wr(8'h80, 32'hffff_ffff);
        rd(8'h80, 32'h0, "unmapped read");
        rd(`ADDR_CTRL, 32'h11c0, "ctrl kept");
        $display("interrupt test done");

        set_src(12'h000);
        lpt_chk(13'h11ce, 1'b1, 1'b1);
        lpt_chk(13'h11ce, 1'b0, 1'b0);
        lpt_chk(13'h11cc, 1'b1, 1'b0);
        lpt_chk(13'h11c6, 1'b1, 1'b1);
        lpt_chk(13'h11c4, 1'b1, 1'b0);
        $display("bidirectional test done");

        // pins 12 and 15 as inputs
        wr(`ADDR_CTRL, 32'h1180);
        @(posedge ref_clk);
        ext_oe  <= 10'h100;
        ext_val <= 10'h000;
        settle();
        chk_bit("dsr2 low", 1'b0, dsr2_n);
        chk_bit("ir rx2 low", 1'b0, ir_rx2);
        chk_bit("line 12 released", 1'b0, pin_oe[`L12]);
        ext_val <= 10'h100;
        settle();
        chk_bit("dsr2 high", 1'b1, dsr2_n);
        cfg(13'h1145, 5'h06);
        @(posedge ref_clk);
        ext_oe  <= 10'h200;
        ext_val <= 10'h200;
        settle();
        chk_val("ext1 oe", 32'h1ff, 32'(pin_oe & 10'h1ff));
        chk_val("ext1 out", 32'h1ff, 32'(pin_out & 10'h1ff));
        ext_val <= 10'h000;
        settle();
        chk_val("ext1 idle", 32'h0, 32'(pin_out & 10'h1ff));
        $display("shared pin test done");
        results();
    end
endmodule
`default_nettype wire
